// ===== core/spve_engine.sv
// Serial program/verify engine: link shifter, command execution, setup word
`timescale 1ns/1ps
module spve_engine import spve_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic serial_program_clock,
  input wire logic serial_program_data_in,
  output logic serial_program_data_out,
  output logic serial_program_data_oe,
  input wire logic program_mode,
  output logic busy,
  output logic [13:0] device_setup_word,
  output logic [1:0] brownout_reset_select,
  output logic [2:0] oscillator_select,
  output logic watchdog_force_on,
  output logic powerup_delay_enable_n,
  output logic reset_pin_function_select,
  output logic failsafe_clock_monitor_enable,
  output logic two_speed_switchover_enable
);
  // ==========================================================
  // Link domain: command and data shifter on the serial clock
  // ==========================================================
  spve_link_t lst_q;
  logic [4:0] cnt_q;
  logic [5:0] cmd_sh_q;
  logic [15:0] dat_sh_q;
  logic [15:0] out_sh_q;
  logic oe_q;
  logic dout_q;
  logic cmd_tog_q;
  logic [5:0] cmd_hold_q;
  logic [13:0] load_hold_q;
  logic [13:0] rd_word;
  logic [5:0] cmd_next;
  logic cmd_is_load;
  logic cmd_is_read;
  logic link_rst;

  assign link_rst = rst | ~program_mode;
  assign cmd_next = {serial_program_data_in, cmd_sh_q[5:1]};
  assign cmd_is_load = (cmd_next == C_LOAD_CFG) | (cmd_next == C_LOAD_PM) |
                       (cmd_next == C_LOAD_DM);
  assign cmd_is_read = (cmd_next == C_READ_PM) | (cmd_next == C_READ_DM);

  // Falling edge samples command and load bits
  always_ff @(negedge serial_program_clock or posedge link_rst) begin
    if (link_rst) begin
      lst_q <= SPVE_CMD;
      cnt_q <= 5'h00;
      cmd_sh_q <= 6'h00;
      dat_sh_q <= 16'h0000;
      cmd_tog_q <= 1'b0;
      cmd_hold_q <= 6'h00;
      load_hold_q <= 14'h0000;
    end else if (lst_q == SPVE_CMD) begin
      cmd_sh_q <= cmd_next;
      cnt_q <= (cnt_q == CMD_LAST) ? 5'h00 : cnt_q + 5'h01;
      if (cnt_q == CMD_LAST) begin
        cmd_hold_q <= cmd_next;
        if (cmd_is_load) lst_q <= SPVE_LOAD;
        else if (cmd_is_read) lst_q <= SPVE_READ;
        if (!cmd_is_load) cmd_tog_q <= ~cmd_tog_q;
      end
    end else begin
      dat_sh_q <= {serial_program_data_in, dat_sh_q[15:1]};
      cnt_q <= (cnt_q == FRAME_LAST) ? 5'h00 : cnt_q + 5'h01;
      if (cnt_q == FRAME_LAST) begin
        lst_q <= SPVE_CMD;
        if (lst_q == SPVE_LOAD) begin
          load_hold_q <= dat_sh_q[15:2];
          cmd_tog_q <= ~cmd_tog_q;
        end
      end
    end
  end

  // Rising edge drives read data
  always_ff @(posedge serial_program_clock or posedge link_rst) begin
    if (link_rst) begin
      oe_q <= 1'b0;
      dout_q <= 1'b0;
      out_sh_q <= 16'h0000;
    end else if (lst_q == SPVE_READ) begin
      if (cnt_q == 5'h00) begin
        oe_q <= 1'b0;
        dout_q <= 1'b0;
        out_sh_q <= {1'b0, rd_word, 1'b0};
      end else if (cnt_q == FRAME_LAST) begin
        oe_q <= 1'b0;
      end else begin
        oe_q <= 1'b1;
        dout_q <= out_sh_q[1];
        out_sh_q <= {1'b0, out_sh_q[15:1]};
      end
    end else begin
      oe_q <= 1'b0;
    end
  end
  assign serial_program_data_out = dout_q;
  assign serial_program_data_oe = oe_q;

  // ==========================================================
  // System domain: command receipt, memories, timer
  // ==========================================================
  logic [2:0] tog_sync_q;
  logic [1:0] mode_sync_q;
  logic cmd_evt;
  logic [13:0] pc_q;
  logic [13:0] latch_q;
  logic [13:0] setup_q;
  logic [13:0] pm_q [PM_WORDS];
  logic [7:0] dm_q [DM_BYTES];
  logic [13:0] rd_q;
  spve_op_t op_q;
  logic [15:0] tmr_q;
  logic busy_q;
  logic ext_q;
  logic [5:0] cmd_s;
  logic [13:0] load_s;
  logic plocked;
  logic dlocked;
  logic in_setup;
  logic row_ok;
  logic [10:0] pm_idx;
  logic [7:0] dm_idx;
  logic [13:0] new_setup;
  logic pm_unlock;
  logic dm_unlock;
  logic dm_sel_q;
  logic wr_setup;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tog_sync_q <= 3'h0;
      mode_sync_q <= 2'h0;
    end else if (clk_en) begin
      tog_sync_q <= {tog_sync_q[1:0], cmd_tog_q};
      mode_sync_q <= {mode_sync_q[0], program_mode};
    end
  end
  // Hold words are written no later than the serial edge that flips the toggle, so they are stable when it is seen
  assign cmd_evt = tog_sync_q[2] ^ tog_sync_q[1];
  assign cmd_s = cmd_hold_q;
  assign load_s = load_hold_q;

  assign plocked = ~setup_q[B_PLOCK];
  assign dlocked = ~setup_q[B_DLOCK];
  assign in_setup = pc_q[13];
  assign row_ok = ~plocked & ~in_setup;
  assign pm_idx = pc_q[10:0];
  assign dm_idx = pc_q[7:0];
  // Setup bits only move toward zero; bit 13 stays one
  assign new_setup = (setup_q & latch_q) | (14'h0001 << B_BUILTIN_ONE);
  // Only a program write aimed at the setup word may write it; a program bulk erase also resets it
  assign wr_setup = (op_q == SPVE_WR) & (pc_q == SETUP_WORD_ADDR) & ~dm_sel_q;
  assign pm_unlock = plocked & latch_q[B_PLOCK] & wr_setup;
  assign dm_unlock = dlocked & latch_q[B_DLOCK] & wr_setup;

  // Read word snapshot for the link; stable during the data frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_q <= 14'h0000;
    end else if (clk_en) begin
      if (in_setup) rd_q <= (pc_q == SETUP_WORD_ADDR) ? setup_q : ERASED_WORD;
      else if (plocked) rd_q <= 14'h0000;
      else rd_q <= pm_q[pm_idx];
    end
  end
  // Data read: eight bits, zeros when locked
  assign rd_word = (cmd_hold_q == C_READ_DM) ?
                   {6'h00, (dlocked ? 8'h00 : dm_q[dm_idx])} : rd_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_q <= 14'h0000;
      latch_q <= ERASED_WORD;
      op_q <= SPVE_NONE;
      tmr_q <= 16'h0000;
      busy_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (clk_en) begin
      if (!mode_sync_q[1]) begin
        pc_q <= 14'h0000;
        busy_q <= 1'b0;
        op_q <= SPVE_NONE;
      end else if (cmd_evt) begin
        unique case (cmd_s)
          C_LOAD_CFG: begin
            pc_q <= SETUP_BASE;
            latch_q <= load_s;
          end
          C_LOAD_PM: latch_q <= load_s;
          C_LOAD_DM: latch_q <= load_s;
          C_INC: pc_q <= in_setup ? {1'b1, pc_q[12:0] + 13'h0001} :
                                    {1'b0, pc_q[12:0] + 13'h0001};
          C_BEGIN_INT, C_BEGIN_EXT: begin
            op_q <= SPVE_WR;
            busy_q <= 1'b1;
            ext_q <= (cmd_s == C_BEGIN_EXT);
            tmr_q <= 16'(WRITE_CYCLES);
          end
          C_END: begin
            if (ext_q) tmr_q <= 16'h0001;
          end
          C_BULK_PM: begin
            op_q <= SPVE_BULK_PM;
            busy_q <= 1'b1;
            ext_q <= 1'b0;
            tmr_q <= 16'(WRITE_CYCLES);
          end
          C_BULK_DM: begin
            op_q <= SPVE_BULK_DM;
            busy_q <= 1'b1;
            ext_q <= 1'b0;
            tmr_q <= 16'(WRITE_CYCLES);
          end
          C_ROW: begin
            if (row_ok) begin
              op_q <= SPVE_ROW;
              busy_q <= 1'b1;
              ext_q <= 1'b0;
              tmr_q <= 16'(WRITE_CYCLES);
            end
          end
          default: ;
        endcase
      end else if (busy_q) begin
        if (!ext_q || tmr_q == 16'h0001) begin
          tmr_q <= tmr_q - 16'h0001;
        end
        if (tmr_q == 16'h0001) begin
          busy_q <= 1'b0;
          op_q <= SPVE_NONE;
        end
      end
    end
  end

  // Setup word commit at end of operation
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      setup_q <= ERASED_WORD;
    end else if (clk_en && busy_q && tmr_q == 16'h0001) begin
      if (op_q == SPVE_BULK_PM) setup_q <= ERASED_WORD;
      else if (wr_setup) setup_q <= new_setup;
    end
  end

  // Memory arrays: writes AND into cells, erases set to ones
  genvar gi;
  generate
    for (gi = 0; gi < PM_WORDS; gi++) begin : g_pm
      always_ff @(posedge sys_clk) begin
        if (clk_en && busy_q && tmr_q == 16'h0001) begin
          if (op_q == SPVE_BULK_PM || pm_unlock) pm_q[gi] <= ERASED_WORD;
          else if (op_q == SPVE_ROW && pc_q[10:4] == 7'(gi >> 4)) pm_q[gi] <= ERASED_WORD;
          else if (op_q == SPVE_WR && !in_setup && !plocked && pc_q[12:11] == 2'h0 &&
                   pm_idx == 11'(gi) && !dm_sel_q)
            pm_q[gi] <= pm_q[gi] & latch_q;
        end
      end
    end
    for (gi = 0; gi < DM_BYTES; gi++) begin : g_dm
      always_ff @(posedge sys_clk) begin
        if (clk_en && busy_q && tmr_q == 16'h0001) begin
          if ((op_q == SPVE_BULK_PM && dlocked) || dm_unlock) dm_q[gi] <= ERASED_BYTE;
          else if (op_q == SPVE_BULK_DM && !dlocked) dm_q[gi] <= ERASED_BYTE;
          else if (op_q == SPVE_WR && dm_idx == 8'(gi) && dm_sel_q)
            dm_q[gi] <= dm_q[gi] & latch_q[7:0];
        end
      end
    end
  endgenerate

  // Remember whether the last load targeted data memory
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) dm_sel_q <= 1'b0;
    else if (clk_en && cmd_evt) begin
      if (cmd_s == C_LOAD_DM) dm_sel_q <= 1'b1;
      else if (cmd_s == C_LOAD_PM || cmd_s == C_LOAD_CFG) dm_sel_q <= 1'b0;
    end
  end

  // ==========================================================
  // Registered decoded setup outputs
  // ==========================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      device_setup_word <= ERASED_WORD;
      brownout_reset_select <= 2'h3;
      oscillator_select <= 3'h7;
      watchdog_force_on <= 1'b1;
      powerup_delay_enable_n <= 1'b1;
      reset_pin_function_select <= 1'b1;
      failsafe_clock_monitor_enable <= 1'b1;
      two_speed_switchover_enable <= 1'b1;
    end else if (clk_en) begin
      busy <= busy_q;
      device_setup_word <= setup_q;
      brownout_reset_select <= setup_q[B_BOR_HI:B_BOR_LO];
      oscillator_select <= setup_q[2:0];
      watchdog_force_on <= setup_q[B_WDT];
      powerup_delay_enable_n <= setup_q[B_PWRT_N];
      reset_pin_function_select <= setup_q[B_RSTPIN];
      failsafe_clock_monitor_enable <= setup_q[B_FCM];
      two_speed_switchover_enable <= setup_q[B_SWO];
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_setup_top;
    @(posedge sys_clk) disable iff (rst) setup_q[B_BUILTIN_ONE];
  endproperty
  a_setup_top: assert property (p_setup_top) else $error("setup bit 13 low");

  property p_cfg_base;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && mode_sync_q[1] && cmd_evt && cmd_s == C_LOAD_CFG) |=> pc_q == SETUP_BASE;
  endproperty
  a_cfg_base: assert property (p_cfg_base) else $error("load setup not at base");

  property p_inc;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && mode_sync_q[1] && cmd_evt && cmd_s == C_INC) |=>
      pc_q[12:0] == $past(pc_q[12:0]) + 13'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("address not incremented");

  property p_setup_stays;
    @(posedge sys_clk) disable iff (rst) in_setup && mode_sync_q[1] |=> in_setup;
  endproperty
  a_setup_stays: assert property (p_setup_stays) else $error("left setup area");

  property p_row_ign;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && mode_sync_q[1] && cmd_evt && cmd_s == C_ROW && !row_ok && !busy_q)
      |=> !busy_q;
  endproperty
  a_row_ign: assert property (p_row_ign) else $error("row erase not ignored");

  property p_int_done;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && busy_q && !ext_q && tmr_q == 16'h0001) |=> !busy_q;
  endproperty
  a_int_done: assert property (p_int_done) else $error("timed write not ended");

  property p_wdt;
    @(posedge sys_clk) disable iff (rst) clk_en |=> watchdog_force_on == $past(setup_q[B_WDT]);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog bit mismatch");

  property p_osc;
    @(posedge sys_clk) disable iff (rst) clk_en |=> oscillator_select == $past(setup_q[2:0]);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator select mismatch");

  property p_oe_off;
    @(posedge serial_program_clock) disable iff (link_rst) lst_q == SPVE_CMD |=> !oe_q;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data line driven in command");

  property p_ext_hold;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && mode_sync_q[1] && busy_q && ext_q && !cmd_evt && tmr_q != 16'h0001)
      |=> busy_q;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external write ended early");

  property p_bulk_setup;
    @(posedge sys_clk) disable iff (rst)
      (clk_en && busy_q && tmr_q == 16'h0001 && op_q == SPVE_BULK_PM)
      |=> setup_q == ERASED_WORD;
  endproperty
  a_bulk_setup: assert property (p_bulk_setup) else $error("setup not erased");
endmodule : spve_engine

// ===== core/spve_pkg.sv
// Constants and types for the serial program/verify engine
package spve_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WRITE_TIME_US = 5;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam logic [13:0] SETUP_BASE = 14'h2000;
  localparam logic [13:0] SETUP_WORD_ADDR = 14'h2007;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int unsigned PM_WORDS = 2048;
  localparam int unsigned DM_BYTES = 256;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] CMD_LAST = 5'h05;
  localparam int unsigned B_BUILTIN_ONE = 13;
  localparam int unsigned B_FCM = 11;
  localparam int unsigned B_SWO = 10;
  localparam int unsigned B_BOR_HI = 9;
  localparam int unsigned B_BOR_LO = 8;
  localparam int unsigned B_DLOCK = 7;
  localparam int unsigned B_PLOCK = 6;
  localparam int unsigned B_RSTPIN = 5;
  localparam int unsigned B_PWRT_N = 4;
  localparam int unsigned B_WDT = 3;
  localparam logic [5:0] C_LOAD_CFG = 6'h00;
  localparam logic [5:0] C_LOAD_PM = 6'h02;
  localparam logic [5:0] C_LOAD_DM = 6'h03;
  localparam logic [5:0] C_READ_PM = 6'h04;
  localparam logic [5:0] C_READ_DM = 6'h05;
  localparam logic [5:0] C_INC = 6'h06;
  localparam logic [5:0] C_BEGIN_INT = 6'h08;
  localparam logic [5:0] C_BEGIN_EXT = 6'h18;
  localparam logic [5:0] C_END = 6'h0A;
  localparam logic [5:0] C_BULK_PM = 6'h09;
  localparam logic [5:0] C_BULK_DM = 6'h0B;
  localparam logic [5:0] C_ROW = 6'h11;
  typedef enum logic [1:0] {SPVE_CMD, SPVE_LOAD, SPVE_READ} spve_link_t;
  typedef enum logic [2:0] {
    SPVE_NONE, SPVE_WR, SPVE_BULK_PM, SPVE_BULK_DM, SPVE_ROW
  } spve_op_t;
endpackage : spve_pkg

// ===== tb/spve_programmer.sv
// Programmer model: drives the serial program clock and data line
`timescale 1ns/1ps
module spve_programmer (
  output logic serial_program_clock,
  output logic serial_program_data_in,
  input wire logic serial_program_data_out,
  input wire logic serial_program_data_oe
);
  // ==========================================================
  // Line level
  logic drv_q;
  assign serial_program_data_in = serial_program_data_oe ? serial_program_data_out : drv_q;
  initial begin
    serial_program_clock = 1'b0;
    drv_q = 1'b0;
  end
  // ==========================================================
  // Frame tasks, clock idle low between frames
  task automatic tick(input logic b);
    serial_program_clock = 1'b1;
    drv_q = b;
    #3;
    serial_program_clock = 1'b0;
    #3;
  endtask : tick
  task automatic send_cmd(input logic [5:0] c);
    #1000;
    for (int i = 0; i < 6; i++) begin
      tick(c[i]);
    end
  endtask : send_cmd
  task automatic send_word(input logic [13:0] w);
    #1000;
    tick(1'b0);
    for (int i = 0; i < 14; i++) begin
      tick(w[i]);
    end
    tick(1'b0);
  endtask : send_word
  task automatic read_word(output logic [13:0] w, output logic [15:0] oe);
    #1000;
    w = 14'h0000;
    for (int i = 0; i < 16; i++) begin
      serial_program_clock = 1'b1;
      drv_q = ~drv_q;
      #3;
      oe[i] = serial_program_data_oe;
      if (i >= 1 && i <= 14) begin
        w[i-1] = serial_program_data_in;
      end
      serial_program_clock = 1'b0;
      #3;
    end
  endtask : read_word
endmodule : spve_programmer

// ===== tb/tb_serial_program_verify_engine.sv
// Self-checking testbench for the serial program/verify engine
`timescale 1ns/1ps
module tb_serial_program_verify_engine import spve_pkg::*;;
  // ==========================================================
  // Signals
  logic sys_clk, rst, clk_en, program_mode, busy;
  logic serial_program_clock, serial_program_data_in;
  logic serial_program_data_out, serial_program_data_oe;
  logic watchdog_force_on, powerup_delay_enable_n, reset_pin_function_select;
  logic failsafe_clock_monitor_enable, two_speed_switchover_enable;
  logic [13:0] device_setup_word, rd_w, d, d2, v;
  logic [1:0] brownout_reset_select;
  logic [2:0] oscillator_select;
  logic [15:0] oe_w;
  int fail_count = 0;
  int checks_done = 0;
  // ==========================================================
  // Instances
  spve_engine spve_engine_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .serial_program_clock(serial_program_clock), .serial_program_data_in(serial_program_data_in),
    .serial_program_data_out(serial_program_data_out),
    .serial_program_data_oe(serial_program_data_oe), .program_mode(program_mode), .busy(busy),
    .device_setup_word(device_setup_word), .brownout_reset_select(brownout_reset_select),
    .oscillator_select(oscillator_select), .watchdog_force_on(watchdog_force_on),
    .powerup_delay_enable_n(powerup_delay_enable_n),
    .reset_pin_function_select(reset_pin_function_select),
    .failsafe_clock_monitor_enable(failsafe_clock_monitor_enable),
    .two_speed_switchover_enable(two_speed_switchover_enable));
  spve_programmer spve_programmer_inst (.serial_program_clock(serial_program_clock),
    .serial_program_data_in(serial_program_data_in),
    .serial_program_data_out(serial_program_data_out),
    .serial_program_data_oe(serial_program_data_oe));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [13:0] exp_setup(input logic [13:0] w);
    return w | 14'h2000;
  endfunction : exp_setup
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic reenter();
    @(posedge sys_clk);
    program_mode <= 1'b0;
    repeat (3) @(posedge sys_clk);
    program_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : reenter
  task automatic ld(input logic [5:0] c, input logic [13:0] w);
    spve_programmer_inst.send_cmd(c);
    spve_programmer_inst.send_word(w);
  endtask : ld
  task automatic op(input logic [5:0] c, input int cyc);
    int n;
    spve_programmer_inst.send_cmd(c);
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge sys_clk);
    if (cyc == 0) begin
      check("refused_busy", 16'h0000, 16'(busy));
    end else begin
      n = 0;
      while (busy === 1'b1 && n < 4 * WRITE_CYCLES) begin
        @(negedge sys_clk);
        n++;
      end
      check("busy_cycles", 16'(cyc), 16'(n));
    end
  endtask : op
  task automatic rd(input logic [5:0] c, input logic [13:0] exp, input string name);
    spve_programmer_inst.send_cmd(c);
    spve_programmer_inst.read_word(rd_w, oe_w);
    check(name, 16'(exp), 16'(rd_w));
    check("oe_window", 16'h7FFE, oe_w);
  endtask : rd
  task automatic write_setup(input logic [13:0] w);
    ld(C_LOAD_CFG, w);
    repeat (7) spve_programmer_inst.send_cmd(C_INC);
    ld(C_LOAD_PM, w);
    op(C_BEGIN_INT, WRITE_CYCLES);
  endtask : write_setup
  task automatic chk_fields(input logic [13:0] w);
    check("setup", 16'(exp_setup(w)), 16'(device_setup_word));
    check("bor", 16'(w[B_BOR_HI:B_BOR_LO]), 16'(brownout_reset_select));
    check("osc", 16'(w[2:0]), 16'(oscillator_select));
    check("wdt", 16'(w[B_WDT]), 16'(watchdog_force_on));
    check("pwrt", 16'(w[B_PWRT_N]), 16'(powerup_delay_enable_n));
    check("rstpin", 16'(w[B_RSTPIN]), 16'(reset_pin_function_select));
    check("fcm", 16'(w[B_FCM]), 16'(failsafe_clock_monitor_enable));
    check("swo", 16'(w[B_SWO]), 16'(two_speed_switchover_enable));
  endtask : chk_fields
  // ==========================================================
  // Watchdog
  initial begin
    repeat (80000) @(posedge sys_clk);
    fail_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    program_mode = 1'b0;
    void'($urandom(15739));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk_fields(ERASED_WORD);
    check("oe_reset", 16'h0000, 16'(serial_program_data_oe));
    reenter();
    op(C_BULK_PM, WRITE_CYCLES);
    op(C_BULK_DM, WRITE_CYCLES);
    d = 14'($urandom() & 32'hFF);
    d2 = 14'($urandom() & 32'hFF);
    ld(C_LOAD_DM, d);
    op(C_BEGIN_INT, WRITE_CYCLES);
    ld(C_LOAD_DM, d2);
    op(C_BEGIN_INT, WRITE_CYCLES);
    rd(C_READ_DM, d & d2, "dm_and");
    spve_programmer_inst.send_cmd(C_INC);
    rd(C_READ_DM, 14'h00FF, "dm_next");
    reenter();
    rd(C_READ_DM, d & d2, "dm_reentry");
    op(C_BULK_DM, WRITE_CYCLES);
    rd(C_READ_DM, 14'h00FF, "dm_bulk");
    spve_programmer_inst.send_cmd(C_BULK_DM);
    repeat (20) @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (600) @(negedge sys_clk);
    check("freeze_busy", 16'h0001, 16'(busy));
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (600) @(negedge sys_clk);
    check("thaw_busy", 16'h0000, 16'(busy));
    v = 14'($urandom());
    ld(C_LOAD_PM, v);
    spve_programmer_inst.send_cmd(C_BEGIN_EXT);
    repeat (300) @(negedge sys_clk);
    check("ext_busy", 16'h0001, 16'(busy));
    spve_programmer_inst.send_cmd(C_END);
    repeat (20) @(negedge sys_clk);
    check("ext_done", 16'h0000, 16'(busy));
    rd(C_READ_PM, v, "pm_ext");
    op(C_ROW, WRITE_CYCLES);
    rd(C_READ_PM, ERASED_WORD, "pm_row");
    for (int i = 0; i < 8; i++) begin
      reenter();
      op(C_BULK_PM, WRITE_CYCLES);
      v = 14'($urandom()) | 14'h00C0;
      v[2:0] = 3'(i);
      write_setup(v);
      chk_fields(v);
      op(C_ROW, 0);
    end
    reenter();
    op(C_BULK_PM, WRITE_CYCLES);
    ld(C_LOAD_DM, d);
    op(C_BEGIN_INT, WRITE_CYCLES);
    write_setup(14'h3F3F);
    reenter();
    rd(C_READ_DM, 14'h0000, "dm_locked");
    rd(C_READ_PM, 14'h0000, "pm_locked");
    op(C_ROW, 0);
    op(C_BULK_PM, WRITE_CYCLES);
    check("setup_bulk", 16'(ERASED_WORD), 16'(device_setup_word));
    rd(C_READ_DM, 14'h00FF, "dm_unlock");
    rd(C_READ_PM, ERASED_WORD, "pm_unlock");
    print_verdict();
  end
endmodule : tb_serial_program_verify_engine
